// ==== dv/sdl_ctrl_model.sv ====
// Purpose: controller model driving commands, termination and temperature pins
// Assumes: every output change lands on a rising edge by non-blocking assignment
// Notes:   a released address bus shows the inverse of its last value
`timescale 1ns/1ns
`default_nettype none

module sdl_ctrl_model
(
  // clock
  input  wire logic                       ref_clk_i,
  // command
  output var logic                        cmd_valid_o,
  output var sdl_pkg::sdl_cmd_t           cmd_kind_o,
  output var logic [1:0]                  mr_sel_o,
  output var logic [sdl_pkg::ADDR_W-1:0]  mr_addr_o,
  output var logic                        chop_o,
  // pins
  output var logic                        odt_o,
  output var logic                        hot_o
);
  import sdl_pkg::*;

  localparam int STROBE_HALF_CYC   = 1;
  localparam int REFRESH_MS_NORMAL = 64;
  localparam int REFRESH_MS_HOT    = 32;

  logic strobe_r;
  logic asr_shadow;
  logic srt_shadow;
  int   refresh_ms;

  initial
  begin
    strobe_r    = 1'h0;
    asr_shadow  = 1'h0;
    srt_shadow  = 1'h0;
    refresh_ms  = REFRESH_MS_NORMAL;
    cmd_valid_o = 1'h0;
    cmd_kind_o  = SDL_CMD_NOP;
    mr_sel_o    = 2'h0;
    mr_addr_o   = 16'h0000;
    chop_o      = 1'h0;
    odt_o       = 1'h0;
    hot_o       = 1'h0;
  end

  // ==========================================================
  // command tasks
  task automatic cmd(input sdl_cmd_t k, input logic [1:0] s, input logic [15:0] a,
                     input logic c);
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'h1;
    cmd_kind_o  <= k;
    mr_sel_o    <= s;
    mr_addr_o   <= a;
    chop_o      <= c;
    @(posedge ref_clk_i);
    cmd_valid_o <= 1'h0;
    cmd_kind_o  <= SDL_CMD_NOP;
    mr_addr_o   <= ~a;
  endtask

  task automatic mr2_write(input logic auto_self_refresh_enable, input logic self_refresh_temp_range);
    if (!(auto_self_refresh_enable && self_refresh_temp_range))
    begin
      cmd(SDL_CMD_MRS, MR_SEL_TWO, {8'h00, self_refresh_temp_range, auto_self_refresh_enable, 6'h00}, 1'h0);
      asr_shadow = auto_self_refresh_enable;
      srt_shadow = self_refresh_temp_range;
    end
  endtask

  // self refresh only if cool or auto or extended
  function automatic logic self_refresh_ok();
    return !hot_o || asr_shadow || srt_shadow;
  endfunction

  // strobe pulse meets high and low widths
  task automatic strobe_pulse();
    @(posedge ref_clk_i);
    strobe_r <= 1'h1;
    repeat (STROBE_HALF_CYC) @(posedge ref_clk_i);
    strobe_r <= 1'h0;
    repeat (STROBE_HALF_CYC) @(posedge ref_clk_i);
  endtask

  task automatic level_enter();
    cmd(SDL_CMD_MRS, MR_SEL_ONE, 16'h0080, 1'h0);
  endtask

  task automatic level_exit();
    strobe_pulse();
    @(posedge ref_clk_i);
    odt_o <= 1'h0;
    repeat (5) @(posedge ref_clk_i);
    cmd(SDL_CMD_MRS, MR_SEL_ONE, 16'h0000, 1'h0);
  endtask

  task automatic set_pins(input logic on_die_termination_pin, input logic hot);
    @(posedge ref_clk_i);
    odt_o <= on_die_termination_pin;
    hot_o <= hot;
    refresh_ms <= hot ? REFRESH_MS_HOT : REFRESH_MS_NORMAL;
  endtask
endmodule

`default_nettype wire

// ==== dv/sdl_mode_ctrl_bench.sv ====
// Purpose: self-checking bench for the mode register function block
// Assumes: controller model issues all commands and pin changes
// Notes:   expectations come from the package timing constants
`timescale 1ns/1ns
`default_nettype none

module sdl_mode_ctrl_bench;
  import sdl_pkg::*;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        cv, bc, on_die_termination_pin, hot, wl, st, dqu, crdy, mrdy, cerr;
  logic        auto_self_refresh_enable, self_refresh_temp_range, ill, fast, mpr, rdm, mval;
  sdl_cmd_t    kind;
  logic [1:0]  sel, loc;
  logic [15:0] addr;
  logic [7:0]  data;
  int          error_cnt = 0;
  int          comparisons = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  sdl_ctrl_model u_m (.ref_clk_i(clk), .cmd_valid_o(cv), .cmd_kind_o(kind), .mr_sel_o(sel),
    .mr_addr_o(addr), .chop_o(bc), .odt_o(on_die_termination_pin), .hot_o(hot));

  sdl_mode_ctrl u_dut (.ref_clk_i(clk), .reset_i(rst), .cmd_valid_i(cv), .cmd_kind_i(kind),
    .mr_sel_i(sel), .mr_addr_i(addr), .burst_chop_i(bc), .on_die_termination_pin_i(on_die_termination_pin),
    .temp_hot_pin_i(hot), .write_level_o(wl), .strobe_term_o(st), .dq_undefined_o(dqu),
    .cmd_ready_o(crdy), .mrs_ready_o(mrdy), .cmd_error_o(cerr),
    .auto_self_refresh_enable_o(auto_self_refresh_enable), .self_refresh_temp_range_o(self_refresh_temp_range), .mr2_illegal_o(ill),
    .sr_fast_rate_o(fast), .multi_purpose_readout_o(mpr), .mpr_loc_o(loc),
    .read_from_mpr_o(rdm), .mpr_data_o(data), .mpr_valid_o(mval));

  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic issue(input sdl_cmd_t k, input logic [1:0] s, input logic [15:0] a,
                       input logic c);
    u_m.cmd(k, s, a, c);
    #1;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    results();
  end

  // ==========================================================
  // tests
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk(crdy, 1);
    chk(mrdy, 1);
    u_m.mr2_write(1'h1, 1'h0);
    #1;
    chk(auto_self_refresh_enable, 1);
    chk(self_refresh_temp_range, 0);
    chk({crdy, mrdy}, 0);
    tk(MRD_CYC);
    chk({crdy, mrdy}, 1);
    tk(MOD_CYC - MRD_CYC);
    chk(crdy, 1);
    u_m.set_pins(1'h0, 1'h1);
    tk(5);
    chk(fast, 1);
    chk(16'(u_m.refresh_ms), 16'h0020);
    chk(u_m.self_refresh_ok(), 1);
    u_m.set_pins(1'h0, 1'h0);
    tk(5);
    chk(fast, 0);
    issue(SDL_CMD_MRS, MR_SEL_TWO, 16'h00C0, 1'h0);
    chk(ill, 1);
    chk({auto_self_refresh_enable, self_refresh_temp_range}, 2);
    tk(MOD_CYC);
    u_m.mr2_write(1'h0, 1'h1);
    #1;
    chk({auto_self_refresh_enable, self_refresh_temp_range, fast}, 3);
    tk(MOD_CYC);
    u_m.mr2_write(1'h0, 1'h0);
    #1;
    chk(fast, 0);
    tk(MOD_CYC);
    u_m.level_enter();
    #1;
    chk({wl, dqu}, 3);
    tk(MOD_CYC);
    issue(SDL_CMD_READ, 2'h0, 16'h0000, 1'h0);
    chk(cerr, 1);
    u_m.set_pins(1'h1, 1'h0);
    tk(5);
    chk(st, 1);
    issue(SDL_CMD_MRS, MR_SEL_ONE, 16'h0000, 1'h0);
    chk({cerr, wl}, 3);
    u_m.level_exit();
    #1;
    chk({wl, dqu, st}, 2);
    tk(MOD_CYC);
    chk({crdy, dqu}, 3);
    tk(1);
    chk(dqu, 0);
    issue(SDL_CMD_MRS, MR_SEL_THREE, 16'h0004, 1'h0);
    chk({mpr, loc}, 4);
    tk(MOD_CYC);
    issue(SDL_CMD_READ, 2'h0, 16'h0000, 1'h0);
    chk({rdm, mval}, 3);
    chk(data, MPR_CAL_PATTERN);
    issue(SDL_CMD_READ_AP, 2'h0, 16'h0000, 1'h1);
    chk(data, MPR_CAL_CHOP);
    issue(SDL_CMD_MRS, MR_SEL_THREE, 16'h0005, 1'h0);
    tk(MOD_CYC);
    issue(SDL_CMD_READ, 2'h0, 16'h0000, 1'h0);
    chk({loc, data}, 10'h100);
    issue(SDL_CMD_MRS, MR_SEL_THREE, 16'h0000, 1'h0);
    chk(mpr, 0);
    tk(MOD_CYC);
    issue(SDL_CMD_READ, 2'h0, 16'h0000, 1'h0);
    chk({rdm, mval, cerr}, 0);
    results();
  end
endmodule

`default_nettype wire

// ==== hw/sdl_mode_ctrl.sv ====
// Purpose: device-side mode register functions: leveling exit, self refresh, readout
// Assumes: commands are decoded on ref_clk_i; odt and temperature arrive as pins
// Notes:
// Notes on behaviour
// - data pins undefined from leveling until one cycle after mode_update_delay after the exit command.
// - any command after mode_update_delay; mode commands after mode_command_spacing.
// - mode_register_two A6 selects automatic self refresh, else manual range.
// - mode_register_two A7 selects extended range; both bits set is illegal.
// - automatic mode scales self refresh with temperature, higher when hot.
// - range bit zero gives normal rate, one gives extended rate.
// - mode_register_three A2 zero: reads and writes use the array.
// - A2 one: reads return the readout location chosen by A1:A0.
// - location zero returns alternating 0,1 pattern in burst order.
`timescale 1ns/1ns
`default_nettype none

module sdl_mode_ctrl
(
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  // decoded command
  input  wire logic                  cmd_valid_i,
  input  wire sdl_pkg::sdl_cmd_t     cmd_kind_i,
  input  wire logic [1:0]            mr_sel_i,
  input  wire logic [sdl_pkg::ADDR_W-1:0] mr_addr_i,
  input  wire logic                  burst_chop_i,
  // pins
  input  wire logic                  on_die_termination_pin_i,
  input  wire logic                  temp_hot_pin_i,
  // leveling and command status
  output logic                       write_level_o,
  output logic                       strobe_term_o,
  output logic                       dq_undefined_o,
  output logic                       cmd_ready_o,
  output logic                       mrs_ready_o,
  output logic                       cmd_error_o,
  // self refresh
  output logic                       auto_self_refresh_enable_o,
  output logic                       self_refresh_temp_range_o,
  output logic                       mr2_illegal_o,
  output logic                       sr_fast_rate_o,
  // readout
  output logic                       multi_purpose_readout_o,
  output logic [1:0]                 mpr_loc_o,
  output logic                       read_from_mpr_o,
  output logic [7:0]                 mpr_data_o,
  output logic                       mpr_valid_o
);
  import sdl_pkg::*;

  typedef struct packed {
    logic [2:0]       odt_sync;
    logic [2:0]       hot_sync;
    logic             odt_f;
    logic             hot_f;
    logic             wl;
    logic             exit_pend;
    logic             dq_undef;
    logic [CNT_W-1:0] mod_cnt;
    logic [CNT_W-1:0] mrd_cnt;
    logic             cmd_ready;
    logic             mrs_ready;
    logic             cmd_err;
    logic             auto_self_refresh_enable;
    logic             self_refresh_temp_range;
    logic             mr2_bad;
    logic             sr_fast;
    logic             mpr_en;
    logic [1:0]       loc;
    logic             rd_mpr;
    logic             term;
  } sdl_state_t;

  sdl_state_t s_r;
  sdl_state_t s_nxt;

  logic is_mrs;
  logic is_read;
  logic is_exit;
  logic allowed;
  logic mrs_acc;
  logic rd_acc;

  // ==========================================================
  // command qualification
  always_comb
  begin
    is_mrs  = cmd_valid_i && (cmd_kind_i == SDL_CMD_MRS);
    is_read = cmd_valid_i && ((cmd_kind_i == SDL_CMD_READ) || (cmd_kind_i == SDL_CMD_READ_AP));
    is_exit = is_mrs && (mr_sel_i == MR_SEL_ONE) && !mr_addr_i[MR1_WL_BIT];
    // only no-ops and exit in leveling
    if (s_r.wl)
      allowed = is_exit && !s_r.odt_f;
    // spacing gates mode and other commands
    else if (is_mrs)
      allowed = s_r.mrs_ready;
    else
      allowed = s_r.cmd_ready;
    mrs_acc = is_mrs && allowed;
    rd_acc  = is_read && allowed;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.odt_sync = {s_r.odt_sync[1:0], on_die_termination_pin_i};
    s_nxt.hot_sync = {s_r.hot_sync[1:0], temp_hot_pin_i};
    if (s_r.odt_sync[1] == s_r.odt_sync[2])
      s_nxt.odt_f = s_r.odt_sync[2];
    if (s_r.hot_sync[1] == s_r.hot_sync[2])
      s_nxt.hot_f = s_r.hot_sync[2];
    s_nxt.cmd_err = cmd_valid_i && (cmd_kind_i != SDL_CMD_NOP) && !allowed;
    s_nxt.mr2_bad = 1'b0;
    s_nxt.rd_mpr  = 1'b0;
    if (s_r.mod_cnt != '0)
      s_nxt.mod_cnt = s_r.mod_cnt - 1'b1;
    if (s_r.mrd_cnt != '0)
      s_nxt.mrd_cnt = s_r.mrd_cnt - 1'b1;
    if (mrs_acc)
    begin
      s_nxt.mod_cnt = CNT_W'(MOD_CYC);
      s_nxt.mrd_cnt = CNT_W'(MRD_CYC);
      unique case (mr_sel_i)
        MR_SEL_ONE:
        begin
          s_nxt.wl = mr_addr_i[MR1_WL_BIT];
          if (s_r.wl && !mr_addr_i[MR1_WL_BIT])
            s_nxt.exit_pend = 1'b1;
        end
        MR_SEL_TWO:
        begin
          if (mr_addr_i[MR2_ASR_BIT] && mr_addr_i[MR2_SRT_BIT])
            s_nxt.mr2_bad = 1'b1;
          else
          begin
            s_nxt.auto_self_refresh_enable = mr_addr_i[MR2_ASR_BIT];
            s_nxt.self_refresh_temp_range = mr_addr_i[MR2_SRT_BIT];
          end
        end
        MR_SEL_THREE:
        begin
          s_nxt.mpr_en = mr_addr_i[MR3_MPR_BIT];
          s_nxt.loc    = mr_addr_i[MR3_LOC_LSB +: 2];
        end
        default:
        begin
          s_nxt.wl = s_r.wl;
        end
      endcase
    end
    // reads served from readout when enabled
    if (rd_acc)
      s_nxt.rd_mpr = s_r.mpr_en;
    if (s_r.exit_pend && (s_r.mod_cnt == '0) && !mrs_acc)
      s_nxt.exit_pend = 1'b0;
    // data pins undefined until one cycle after the exit delay ends
    s_nxt.dq_undef  = s_nxt.wl || s_nxt.exit_pend;
    // strobe termination registered so the output leaves a flop
    s_nxt.term      = s_nxt.wl && s_nxt.odt_f;
    s_nxt.cmd_ready = (s_nxt.mod_cnt == '0);
    s_nxt.mrs_ready = (s_nxt.mrd_cnt == '0);
    s_nxt.sr_fast   = s_nxt.auto_self_refresh_enable ? s_nxt.hot_f : s_nxt.self_refresh_temp_range;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      s_r           <= '0;
      s_r.cmd_ready <= 1'b1;
      s_r.mrs_ready <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // readout data
  // calibration pattern source
  sdl_mpr_pattern u_pattern
  (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .load_i    (rd_acc && s_r.mpr_en),
    .loc_i     (s_r.loc),
    .chop_i    (burst_chop_i),
    .beats_o   (mpr_data_o),
    .valid_o   (mpr_valid_o)
  );

  // ==========================================================
  // outputs
  assign write_level_o              = s_r.wl;
  assign strobe_term_o              = s_r.term;
  assign dq_undefined_o             = s_r.dq_undef;
  assign cmd_ready_o                = s_r.cmd_ready;
  assign mrs_ready_o                = s_r.mrs_ready;
  assign cmd_error_o                = s_r.cmd_err;
  assign auto_self_refresh_enable_o = s_r.auto_self_refresh_enable;
  assign self_refresh_temp_range_o  = s_r.self_refresh_temp_range;
  assign mr2_illegal_o              = s_r.mr2_bad;
  assign sr_fast_rate_o             = s_r.sr_fast;
  assign multi_purpose_readout_o    = s_r.mpr_en;
  assign mpr_loc_o                  = s_r.loc;
  assign read_from_mpr_o            = s_r.rd_mpr;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  logic mr2_acc;
  logic mr2_both;
  assign mr2_acc  = mrs_acc && (mr_sel_i == MR_SEL_TWO);
  assign mr2_both = mr_addr_i[MR2_ASR_BIT] && mr_addr_i[MR2_SRT_BIT];

  sequence exit_taken;
    s_r.wl && is_exit && allowed;
  endsequence

  a_dq_undef_exit: assert property (exit_taken |=> dq_undefined_o && !write_level_o)
    else $error("data pins not undefined after leveling exit");
  a_mrs_blocks_cmd: assert property (mrs_acc |=> !cmd_ready_o && !mrs_ready_o)
    else $error("ready not dropped after mode command");
  a_mr2_never_both: assert property (!(auto_self_refresh_enable_o && self_refresh_temp_range_o))
    else $error("both self refresh bits set");
  a_mr2_bad_kept: assert property (mr2_acc && mr2_both |=> mr2_illegal_o && $stable(auto_self_refresh_enable_o) && $stable(self_refresh_temp_range_o))
    else $error("illegal mode_register_two write not refused");
  a_asr_from_bit: assert property (mr2_acc && !mr2_both |=> auto_self_refresh_enable_o == $past(mr_addr_i[MR2_ASR_BIT]))
    else $error("auto self refresh bit not taken");
  a_sr_rate_auto: assert property (auto_self_refresh_enable_o |-> sr_fast_rate_o == s_r.hot_f)
    else $error("auto rate does not follow temperature");
  a_sr_rate_manual: assert property (!auto_self_refresh_enable_o |-> sr_fast_rate_o == self_refresh_temp_range_o)
    else $error("manual rate does not follow range bit");
  a_read_array: assert property (rd_acc && !s_r.mpr_en |=> !read_from_mpr_o && !mpr_valid_o)
    else $error("array read diverted to readout");
  a_read_mpr: assert property (rd_acc && s_r.mpr_en |=> read_from_mpr_o && mpr_valid_o)
    else $error("readout read not served");
  a_cal_pattern: assert property (rd_acc && s_r.mpr_en && s_r.loc == MPR_LOC_CAL && !burst_chop_i |=> mpr_data_o == MPR_CAL_PATTERN)
    else $error("calibration pattern wrong");

endmodule

`default_nettype wire

// ==== hw/sdl_mpr_pattern.sv ====
// Purpose: registered source of predefined readout burst data
// Assumes: load is a one-cycle pulse per accepted read while readout is enabled
// Notes:   burst beat 0 sits in bit 0
`timescale 1ns/1ns
`default_nettype none

module sdl_mpr_pattern
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // request
  input  wire logic       load_i,
  input  wire logic [1:0] loc_i,
  input  wire logic       chop_i,
  // burst data
  output logic      [7:0] beats_o,
  output logic            valid_o
);
  import sdl_pkg::*;

  typedef struct packed {
    logic [7:0] beats;
    logic       valid;
  } sdl_pat_t;

  sdl_pat_t s_r;
  sdl_pat_t s_nxt;

  // ==========================================================
  // pattern select
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.valid = load_i;
    if (load_i)
    begin
      if (loc_i != MPR_LOC_CAL)
        s_nxt.beats = MPR_RFU_DATA;
      else if (chop_i)
        s_nxt.beats = {4'h0, MPR_CAL_CHOP};
      else
        s_nxt.beats = MPR_CAL_PATTERN;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign beats_o = s_r.beats;
  assign valid_o = s_r.valid;

endmodule

`default_nettype wire

// ==== hw/sdl_pkg.sv ====
// Purpose: shared constants and types for the mode register function block
// Assumes: command clock at 20 MHz, commands decoded ahead of this block
// Notes:   timing figures are plain defaults, expressed in ns
package sdl_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS       = 50;
  localparam int MODE_UPDATE_NS      = 200;
  localparam int MODE_CMD_SPACING_NS = 100;
  localparam int MOD_CYC_RAW = (MODE_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MRD_CYC_RAW = (MODE_CMD_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MOD_CYC     = (MOD_CYC_RAW < 1) ? 1 : MOD_CYC_RAW;
  localparam int MRD_CYC     = (MRD_CYC_RAW < 1) ? 1 : MRD_CYC_RAW;
  localparam int CNT_W       = 8;

  // ==========================================================
  // mode register selects and field positions
  localparam logic [1:0] MR_SEL_ONE   = 2'h1;
  localparam logic [1:0] MR_SEL_TWO   = 2'h2;
  localparam logic [1:0] MR_SEL_THREE = 2'h3;
  localparam int ADDR_W       = 16;
  localparam int MR1_WL_BIT   = 7;
  localparam int MR2_ASR_BIT  = 6;
  localparam int MR2_SRT_BIT  = 7;
  localparam int MR3_MPR_BIT  = 2;
  localparam int MR3_LOC_LSB  = 0;

  // ==========================================================
  // readout locations and pattern
  localparam logic [1:0] MPR_LOC_CAL     = 2'h0;
  localparam logic [7:0] MPR_CAL_PATTERN = 8'hAA;
  localparam logic [3:0] MPR_CAL_CHOP    = 4'hA;
  localparam logic [7:0] MPR_RFU_DATA    = 8'h00;

  // ==========================================================
  // decoded command kinds
  typedef enum logic [2:0] {
    SDL_CMD_NOP,
    SDL_CMD_MRS,
    SDL_CMD_READ,
    SDL_CMD_READ_AP,
    SDL_CMD_WRITE,
    SDL_CMD_OTHER
  } sdl_cmd_t;

endpackage
